//--- match_based_pwm_timer.sv
// Match-based PWM timer with a classic Wishbone register slave.
`include "pwm_timer_regs.svh"
`default_nettype none
module match_based_pwm_timer (
   input  wire logic                  clk,     // 10 MHz clock.
   input  wire logic                  reset_n, // Asynchronous reset.
   input  wire pwm_timer_pkg::wb_req_s wbReq,  // Bus request.
   output var  pwm_timer_pkg::wb_rsp_s wbRsp,  // Bus answer.
   output logic [5:0]                 pwmPin,  // Gated PWM outputs.
   output logic                       irq      // Match interrupt.
);
   import pwm_timer_pkg::*;

   state_s      state_reg;
   state_s      state_next;
   logic        tick;
   logic        cycMatch;
   logic [6:0]  matchHit;
   logic        access;
   logic [31:0] wmask;
   logic [31:0] rdata;
   logic        mapped;
   logic [2:0]  matchIdx;

   // A prescaler wrap is the only moment the counter may step. The wrap
   // also fires past the limit, so lowering the prescale on the fly
   // cannot strand the divider for a full 32-bit lap.
   assign tick = state_reg.enable && !state_reg.cntReset &&
                 (state_reg.preCount >= state_reg.prescale);

   // Matches are judged on the live count only at a prescaler wrap.
   always_comb begin
      for (int i = 0; i < `PWM_NUM_MATCH; i++) begin
         matchHit[i] = tick &&
                       (state_reg.count == state_reg.active[i]);
      end
   end

   // The cycle match ends the period whenever PWM mode is on.
   assign cycMatch = matchHit[0] &&
                     (state_reg.pwmMode || state_reg.resetOn[0]);

   // A new request is taken when no answer is pending.
   assign access = wbReq.cyc && wbReq.stb && !state_reg.rsp.ack;
   assign matchIdx = 3'((wbReq.adr - `PWM_OFS_MATCH0) >> 2);
   assign wmask = {{8{wbReq.sel[3]}}, {8{wbReq.sel[2]}},
                   {8{wbReq.sel[1]}}, {8{wbReq.sel[0]}}};

   // Read decode; unmapped addresses answer with zero.
   always_comb begin
      rdata  = `PWM_RESET_WORD;
      mapped = 1'b1;
      case (wbReq.adr)
         `PWM_OFS_CTRL:      rdata = {29'h0, state_reg.pwmMode,
                                      state_reg.cntReset, state_reg.enable};
         `PWM_OFS_COUNT:     rdata = state_reg.count;
         `PWM_OFS_PRESCALE:  rdata = state_reg.prescale;
         `PWM_OFS_PRECOUNT:  rdata = state_reg.preCount;
         `PWM_OFS_MATCHCTRL: begin
            for (int i = 0; i < `PWM_NUM_MATCH; i++) begin
               rdata[3*i+`PWM_MC_IRQ]   = state_reg.irqEn[i];
               rdata[3*i+`PWM_MC_RESET] = state_reg.resetOn[i];
               rdata[3*i+`PWM_MC_STOP]  = state_reg.stopOn[i];
            end
         end
         `PWM_OFS_FLAGS:     rdata = {25'h0, state_reg.flags};
         `PWM_OFS_OUTCTRL:   rdata = {18'h0, state_reg.outEn,
                                      2'h0, state_reg.dblEdge};
         `PWM_OFS_RELEASE:   rdata = {25'h0, state_reg.relPend};
         default: begin
            // The upper bound keeps higher addresses from aliasing onto
            // the match registers through the three-bit index.
            if (wbReq.adr >= `PWM_OFS_MATCH0 && wbReq.adr[1:0] == 2'h0 &&
                wbReq.adr < 8'(`PWM_OFS_MATCH0 + 4 * `PWM_NUM_MATCH)) begin
               rdata = state_reg.shadow[matchIdx];
            end else begin
               mapped = 1'b0;
            end
         end
      endcase
   end

   // Next-state logic: counting, matches, outputs and register writes.
   always_comb begin
      logic [6:0] clearFlags;
      logic [6:0] relSet;
      logic       doReset;
      logic       doStop;
      logic       setOut;
      logic       clrOut;
      clearFlags = 7'h0;
      relSet     = 7'h0;
      doReset    = 1'b0;
      doStop     = 1'b0;
      setOut     = 1'b0;
      clrOut     = 1'b0;
      state_next = state_reg;

      // Bus answer is one cycle after the request is taken.
      state_next.rsp.ack = access;
      state_next.rsp.dat = access && !wbReq.we ? rdata : `PWM_RESET_WORD;

      // Prescaler divides the clock before each count step.
      if (state_reg.cntReset) begin
         state_next.preCount = `PWM_RESET_WORD;
      end else if (state_reg.enable) begin
         state_next.preCount = tick ? `PWM_RESET_WORD
                                    : state_reg.preCount + 32'h1;
      end

      // Reset and stop actions per match; counting goes on otherwise.
      for (int i = 0; i < `PWM_NUM_MATCH; i++) begin
         if (matchHit[i] && state_reg.resetOn[i]) begin
            doReset = 1'b1;
         end
         if (matchHit[i] && state_reg.stopOn[i]) begin
            doStop = 1'b1;
         end
      end
      if (cycMatch) begin
         doReset = 1'b1;
      end
      if (state_reg.cntReset) begin
         state_next.count = `PWM_RESET_WORD;
      end else if (tick) begin
         // A stopping match leaves the count on the matched value unless a reset fires on the same wrap.
         if (doReset) begin
            state_next.count = `PWM_RESET_WORD;
         end else if (!doStop) begin
            state_next.count = state_reg.count + 32'h1;
         end
      end
      if (doStop) begin
         state_next.enable = 1'b0;
      end

      // Match flags are sticky; a new match beats a same-cycle clear.
      if (access && wbReq.we && wbReq.adr == `PWM_OFS_FLAGS) begin
         clearFlags = wbReq.dat[6:0] & wmask[6:0];
      end
      state_next.flags = (state_reg.flags & ~clearFlags) |
                         matchHit;

      // Released match values enter at the period boundary only, so a
      // half-written pair can never produce a stray edge. In plain timer
      // mode there is no pulse to protect and release is immediate.
      for (int i = 0; i < `PWM_NUM_MATCH; i++) begin
         if (state_reg.relPend[i] && (cycMatch || !state_reg.pwmMode)) begin
            state_next.active[i]  = state_reg.shadow[i];
            state_next.relPend[i] = 1'b0;
         end
      end

      // Output k goes high at the cycle match (single edge) or at match k
      // (double edge) and low at match k+1; the fall wins a tie, and a
      // single-edge output whose match k+1 is zero never rises.
      for (int k = 0; k < `PWM_NUM_OUT; k++) begin
         if (state_reg.dblEdge[k] && k != 0) begin
            setOut = matchHit[k];
         end else begin
            setOut = cycMatch && state_reg.active[k+1] != 32'h0;
         end
         clrOut = matchHit[k+1];
         if (!state_reg.pwmMode) begin
            state_next.pwm[k] = 1'b0;
         end else if (clrOut) begin
            state_next.pwm[k] = 1'b0;
         end else if (setOut) begin
            state_next.pwm[k] = 1'b1;
         end
      end

      // Register writes; byte lanes honoured on wide fields.
      if (access && wbReq.we) begin
         case (wbReq.adr)
            `PWM_OFS_CTRL: begin
               if (wbReq.sel[0]) begin
                  state_next.enable   = wbReq.dat[`PWM_CTRL_ENABLE];
                  state_next.cntReset = wbReq.dat[`PWM_CTRL_RESET];
                  state_next.pwmMode  = wbReq.dat[`PWM_CTRL_PWMMODE];
               end
            end
            `PWM_OFS_COUNT: begin
               state_next.count = (state_reg.count & ~wmask) |
                                  (wbReq.dat & wmask);
            end
            `PWM_OFS_PRESCALE: begin
               state_next.prescale = (state_reg.prescale & ~wmask) |
                                     (wbReq.dat & wmask);
            end
            `PWM_OFS_MATCHCTRL: begin
               for (int i = 0; i < `PWM_NUM_MATCH; i++) begin
                  if (wmask[3*i]) begin
                     state_next.irqEn[i]   = wbReq.dat[3*i+`PWM_MC_IRQ];
                     state_next.resetOn[i] = wbReq.dat[3*i+`PWM_MC_RESET];
                     state_next.stopOn[i]  = wbReq.dat[3*i+`PWM_MC_STOP];
                  end
               end
            end
            `PWM_OFS_OUTCTRL: begin
               if (wbReq.sel[0]) begin
                  state_next.dblEdge = wbReq.dat[5:0];
               end
               if (wbReq.sel[1]) begin
                  state_next.outEn =
                     wbReq.dat[`PWM_OC_ENABLE_LSB +: 6];
               end
            end
            `PWM_OFS_RELEASE: begin
               if (wbReq.sel[0]) begin
                  relSet = wbReq.dat[6:0];
               end
            end
            default: begin
               if (mapped && wbReq.adr >= `PWM_OFS_MATCH0) begin
                  state_next.shadow[matchIdx] =
                     (state_reg.shadow[matchIdx] & ~wmask) |
                     (wbReq.dat & wmask);
               end
            end
         endcase
      end
      // A software release beats the hardware clear of the same cycle.
      state_next.relPend = state_next.relPend | relSet;

      // Pins are gated copies of the waveforms, held in flip-flops.
      state_next.pins = state_next.pwm & state_next.outEn;

      // The request follows the flags and enables that will be held next,
      // so a mask write takes effect on the same edge as the flags.
      state_next.irq = |(state_next.flags & state_next.irqEn);
   end

   // The whole state registers here.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign wbRsp  = state_reg.rsp;
   assign pwmPin = state_reg.pins;
   assign irq    = state_reg.irq;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   property p_prescale_wrap;
      tick && !state_reg.cntReset |=> state_reg.preCount == 32'h0;
   endproperty
   a_prescale_wrap: assert property (p_prescale_wrap)
      else $error("Prescaler did not wrap.");

   property p_count_step;
      tick && !cycMatch
         && (matchHit & (state_reg.resetOn | state_reg.stopOn)) == 7'h0
         && !(access && wbReq.we && wbReq.adr == `PWM_OFS_COUNT)
         |=> state_reg.count == $past(state_reg.count) + 32'h1;
   endproperty
   a_count_step: assert property (p_count_step)
      else $error("Counter did not advance on a prescaler wrap.");

   property p_cycle_reset;
      state_reg.pwmMode && matchHit[0]
         && !(access && wbReq.we && wbReq.adr == `PWM_OFS_COUNT)
         |=> state_reg.count == 32'h0;
   endproperty
   a_cycle_reset: assert property (p_cycle_reset)
      else $error("Cycle match did not reset the count.");

   property p_single_rise;
      state_reg.pwmMode && cycMatch && !state_reg.dblEdge[2]
         && state_reg.active[3] != 32'h0 && !matchHit[3]
         |=> state_reg.pwm[2] ##0 (state_reg.pins[2] == state_reg.outEn[2]);
   endproperty
   a_single_rise: assert property (p_single_rise)
      else $error("Single-edge output did not rise at cycle start.");

   property p_edge_fall;
      state_reg.pwmMode && matchHit[2] |=> !state_reg.pwm[1];
   endproperty
   a_edge_fall: assert property (p_edge_fall)
      else $error("Output did not fall at its match.");

   property p_double_rise;
      state_reg.pwmMode && state_reg.dblEdge[3] && matchHit[3]
         && !matchHit[4] |=> state_reg.pwm[3];
   endproperty
   a_double_rise: assert property (p_double_rise)
      else $error("Double-edge output did not rise at its match.");

   property p_flag_irq;
      matchHit[1] && state_reg.irqEn[1]
         && !(access && wbReq.we && wbReq.adr == `PWM_OFS_MATCHCTRL)
         |=> state_reg.flags[1] ##0 state_reg.irq;
   endproperty
   a_flag_irq: assert property (p_flag_irq)
      else $error("Match did not flag and request an interrupt.");

   property p_stop;
      matchHit[1] && state_reg.stopOn[1] && !(access && wbReq.we)
         && !cycMatch && (matchHit & state_reg.resetOn) == 7'h0
         |=> !state_reg.enable && $stable(state_reg.count)
         ##1 $stable(state_reg.count);
   endproperty
   a_stop: assert property (p_stop)
      else $error("Stop-on-match did not halt the counter.");

   property p_release;
      state_reg.pwmMode && state_reg.relPend[1] && !cycMatch
         |=> $stable(state_reg.active[1]);
   endproperty
   a_release: assert property (p_release)
      else $error("Released value applied before cycle end.");

   property p_timer_quiet;
      !state_reg.pwmMode |=> state_reg.pwm == 6'h0;
   endproperty
   a_timer_quiet: assert property (p_timer_quiet)
      else $error("PWM waveform seen in timer mode.");

   property p_ack_once;
      state_reg.rsp.ack |=> !state_reg.rsp.ack;
   endproperty
   a_ack_once: assert property (p_ack_once)
      else $error("Bus answer lasted more than one cycle.");

   property p_double_fall;
      state_reg.pwmMode && state_reg.dblEdge[3] && matchHit[4]
         |=> !state_reg.pwm[3];
   endproperty
   a_double_fall: assert property (p_double_fall)
      else $error("Double-edge output did not fall at its match.");

   property p_flag_clear;
      access && wbReq.we && wbReq.adr == `PWM_OFS_FLAGS && wbReq.sel[0]
         && wbReq.dat[1] && !matchHit[1]
         |=> !state_reg.flags[1];
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("Writing one did not clear a match flag.");

   property p_irq_level;
      state_reg.irq == |(state_reg.flags & state_reg.irqEn);
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("Interrupt request does not follow the enabled flags.");

   property p_pins_gated;
      state_reg.pins == (state_reg.pwm & state_reg.outEn);
   endproperty
   a_pins_gated: assert property (p_pins_gated)
      else $error("Pin differs from its gated waveform.");
endmodule : match_based_pwm_timer
`default_nettype wire

//--- pwm_timer_regs.svh
// Register offsets, field positions, reset values and sizes of the PWM timer.
// Behaviour
// - A 32-bit count steps once per wrap of a 32-bit prescaler.
// - Seven match registers serve six single or three double-edge outputs.
// - In PWM mode a cycle match resets the count and sets the period.
// - Single-edge outputs rise at each cycle match unless held low.
// - Each single-edge output has one match register for its falling edge.
// - Each double-edge output has two match registers for its two edges.
// - Rise before fall gives a positive pulse, fall first a negative one.
// - Each match may request an enabled interrupt while counting goes on.
// - Each match may stop or reset the counter, with or without interrupt.
// - In PWM mode released match values take effect only at a cycle boundary; in timer mode at once.
// - Period and width may be any count value up to the counter width.
// - All PWM outputs share the one period of the cycle match register.
// - Without PWM mode the block is a plain timer with no PWM waveforms.
`ifndef PWM_TIMER_REGS_SVH
`define PWM_TIMER_REGS_SVH

`define PWM_NUM_MATCH      7
`define PWM_NUM_OUT        6

`define PWM_OFS_CTRL       8'h00
`define PWM_OFS_COUNT      8'h04
`define PWM_OFS_PRESCALE   8'h08
`define PWM_OFS_PRECOUNT   8'h0c
`define PWM_OFS_MATCHCTRL  8'h10
`define PWM_OFS_FLAGS      8'h14
`define PWM_OFS_OUTCTRL    8'h18
`define PWM_OFS_RELEASE    8'h1c
`define PWM_OFS_MATCH0     8'h20

`define PWM_CTRL_ENABLE    0
`define PWM_CTRL_RESET     1
`define PWM_CTRL_PWMMODE   2

`define PWM_MC_IRQ         0
`define PWM_MC_RESET       1
`define PWM_MC_STOP        2

`define PWM_OC_ENABLE_LSB  8

`define PWM_RESET_WORD     32'h0000_0000

`endif

//--- pwm_timer_pkg.sv
// Types shared by the PWM timer and its bench.
`default_nettype none
package pwm_timer_pkg;
   typedef logic [31:0] word_t;

   typedef struct packed {
      logic       cyc;
      logic       stb;
      logic       we;
      logic [7:0] adr;
      logic [3:0] sel;
      word_t      dat;
   } wb_req_s;

   typedef struct packed {
      logic  ack;
      word_t dat;
   } wb_rsp_s;

   typedef struct packed {
      logic                enable;
      logic                cntReset;
      logic                pwmMode;
      word_t               count;
      word_t               prescale;
      word_t               preCount;
      logic [6:0][31:0]    shadow;
      logic [6:0][31:0]    active;
      logic [6:0]          irqEn;
      logic [6:0]          resetOn;
      logic [6:0]          stopOn;
      logic [6:0]          flags;
      logic [5:0]          dblEdge;
      logic [5:0]          outEn;
      logic [6:0]          relPend;
      logic [5:0]          pwm;
      logic [5:0]          pins;
      logic                irq;
      wb_rsp_s             rsp;
   } state_s;
endpackage : pwm_timer_pkg
`default_nettype wire

//--- tb.sv
// Self-checking bench for the match-based PWM timer.
`include "pwm_timer_regs.svh"
`default_nettype none
`define CHK(got, exp) \
   begin \
      numChecks++; \
      if ((got) !== (exp)) begin \
         failCount++; \
         $display("ERROR at %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import pwm_timer_pkg::*;

   logic       clk;
   logic       reset_n;
   wb_req_s    wbReq;
   wb_rsp_s    wbRsp;
   logic [5:0] pwmPin;
   logic       irq;
   int         failCount;
   int         numChecks;
   word_t      rd;
   logic [5:0] smp [0:29];

   match_based_pwm_timer uut (
      .clk     (clk),
      .reset_n (reset_n),
      .wbReq   (wbReq),
      .wbRsp   (wbRsp),
      .pwmPin  (pwmPin),
      .irq     (irq)
   );

   // 10 MHz clock.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // One classic cycle; the request stands until ack is sampled high.
   task automatic wb(input logic we, input logic [7:0] adr, input word_t dat);
      int n;
      @(posedge clk);
      wbReq <= '{cyc:1'b1, stb:1'b1, we:we, adr:adr, sel:4'hf, dat:dat};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wbRsp.ack !== 1'b1 && n < 20);
      if (n >= 20) begin
         failCount++;
         $display("ERROR at %0t: no bus answer", $time);
      end
      rd = wbRsp.dat;
      wbReq <= '0;
   endtask : wb

   task automatic wr(input logic [7:0] adr, input word_t dat);
      wb(1'b1, adr, dat);
   endtask : wr

   task automatic rdReg(input logic [7:0] adr);
      wb(1'b0, adr, 32'h0);
   endtask : rdReg

   // Let waveforms settle, then record 30 pin samples.
   task automatic grab;
      repeat (30) @(posedge clk);
      for (int i = 0; i < 30; i++) begin
         @(posedge clk);
         smp[i] = pwmPin;
      end
   endtask : grab

   // Four-state count, so an unknown pin never passes as a match.
   function automatic logic [7:0] highs(input int b);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 20; i++) c += {7'h00, smp[i][b]};
      return c;
   endfunction : highs

   task automatic checkPeriod;
      for (int i = 0; i < 20; i++) `CHK(smp[i + 10], smp[i])
   endtask : checkPeriod

   // All registers start at zero, unmapped places read zero.
   task automatic resetValues;
      for (int a = 0; a < 16; a++) begin
         rdReg(8'(a * 4));
         `CHK(rd, 32'h0)
      end
      rdReg(8'hfc);
      `CHK(rd, 32'h0)
      `CHK({pwmPin, irq}, 7'h00)
   endtask : resetValues

   // Prescaled count, stop on match, flag, mask and clear.
   task automatic stopAndFlags;
      int n;
      wr(`PWM_OFS_PRESCALE, 32'h3);
      wr(`PWM_OFS_MATCH0 + 8'h04, 32'h5);
      wr(`PWM_OFS_RELEASE, 32'h2);
      wr(`PWM_OFS_MATCHCTRL, 32'h28);
      wr(`PWM_OFS_CTRL, 32'h1);
      n = 0;
      while (irq !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      `CHK((n >= 18 && n <= 30), 1'b1)
      rdReg(`PWM_OFS_COUNT);
      `CHK(rd, 32'h5)
      rdReg(`PWM_OFS_CTRL);
      `CHK(rd[0], 1'b0)
      rdReg(`PWM_OFS_RELEASE);
      `CHK(rd[6:0], 7'h00)
      rdReg(`PWM_OFS_FLAGS);
      // Every match register still at zero matched the first zero count.
      `CHK(rd[6:0], 7'h7f)
      wr(`PWM_OFS_MATCHCTRL, 32'h20);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
      wr(`PWM_OFS_MATCHCTRL, 32'h28);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b1)
      wr(`PWM_OFS_FLAGS, 32'h2);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
      rdReg(`PWM_OFS_FLAGS);
      `CHK(rd[6:0], 7'h7d)
      wr(`PWM_OFS_MATCHCTRL, 32'h0);
   endtask : stopAndFlags

   // Timer mode with reset on match; enabled pins must stay quiet.
   task automatic timerMode;
      wr(`PWM_OFS_CTRL, 32'h2);
      wr(`PWM_OFS_PRESCALE, 32'h0);
      wr(`PWM_OFS_MATCH0 + 8'h08, 32'h3);
      wr(`PWM_OFS_RELEASE, 32'h4);
      wr(`PWM_OFS_MATCHCTRL, 32'h80);
      wr(`PWM_OFS_OUTCTRL, 32'h3f00);
      wr(`PWM_OFS_CTRL, 32'h1);
      for (int i = 0; i < 4; i++) begin
         rdReg(`PWM_OFS_COUNT);
         `CHK((rd <= 32'h3), 1'b1)
      end
      grab();
      for (int i = 0; i < 30; i++) `CHK(smp[i], 6'h00)
      wr(`PWM_OFS_CTRL, 32'h2);
      wr(`PWM_OFS_MATCHCTRL, 32'h0);
   endtask : timerMode

   // Period 10: single, constant low, positive and negative pulses.
   task automatic pwmShapes;
      word_t mv [0:6];
      logic [7:0] both;
      mv = '{32'h9, 32'h3, 32'h0, 32'h2, 32'h6, 32'h7, 32'h1};
      for (int i = 0; i < 7; i++) wr(8'(`PWM_OFS_MATCH0 + i * 4), mv[i]);
      wr(`PWM_OFS_RELEASE, 32'h7f);
      wr(`PWM_OFS_OUTCTRL, 32'h2b28);
      wr(`PWM_OFS_CTRL, 32'h5);
      grab();
      checkPeriod();
      `CHK(highs(0), 8'h08)
      `CHK(highs(1), 8'h00)
      `CHK(highs(3), 8'h08)
      `CHK(highs(5), 8'h08)
      `CHK({highs(2), highs(4)}, 16'h0000)
      both = 8'h00;
      for (int i = 0; i < 20; i++) both += {7'h00, smp[i][3] & smp[i][5]};
      `CHK(both, 8'h00)
      // A written but unreleased value must not move the edge.
      wr(`PWM_OFS_MATCH0 + 8'h04, 32'h5);
      grab();
      `CHK(highs(0), 8'h08)
      wr(`PWM_OFS_RELEASE, 32'h2);
      grab();
      `CHK(highs(0), 8'h0c)
      checkPeriod();
   endtask : pwmShapes

   task automatic conclude;
      $display("checks %0d mismatches %0d", numChecks, failCount);
      if (failCount == 0 && numChecks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude

   // Watchdog: the tests need far fewer than 20000 cycles.
   initial begin
      #2000000;
      failCount++;
      $display("ERROR at %0t: watchdog expired", $time);
      conclude();
   end

   // Main sequence.
   initial begin
      reset_n = 1'b0;
      wbReq = '0;
      failCount = 0;
      numChecks = 0;
      rd = 32'h0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      resetValues();
      stopAndFlags();
      timerMode();
      pwmShapes();
      conclude();
   end
endmodule : tb
`default_nettype wire
